// ---- rtl/ecte_pkg.sv ----
// Constants shared by the electronic cam table editor.
package ecte_pkg;
   // =========================================================
   // Register bus
   localparam int          ECTE_AW          = 8;
   localparam int          ECTE_DW          = 32;
   localparam logic [7:0]  ADDR_CTRL        = 8'h40;
   localparam logic [7:0]  ADDR_CYCLE       = 8'h41;
   localparam logic [7:0]  ADDR_STROKE      = 8'h42;
   localparam logic [7:0]  ADDR_ADVAMT      = 8'h43;
   localparam logic [7:0]  ADDR_ADVSPD      = 8'h44;
   localparam logic [7:0]  ADDR_PCHG        = 8'h45;
   localparam logic [7:0]  ADDR_EDITPAT     = 8'h50;
   localparam logic [7:0]  ADDR_EDITCURVE   = 8'h51;
   localparam logic [7:0]  ADDR_RDREQ       = 8'h54;
   localparam logic [7:0]  ADDR_WRREQ       = 8'h55;
   localparam logic [7:0]  ADDR_RDRES       = 8'h58;
   localparam logic [7:0]  ADDR_WRRES       = 8'h59;
   localparam logic [7:0]  ADDR_INTSTAT     = 8'h60;
   localparam logic [7:0]  ADDR_INTMASK     = 8'h61;
   localparam logic [7:0]  ADDR_STATUS      = 8'h62;
   localparam logic [7:0]  ADDR_PHASE       = 8'h63;
   // =========================================================
   // Fields
   localparam int          CTRL_CAMEN       = 0;
   localparam int          CTRL_ADVEN       = 1;
   localparam int          CTRL_PAT_LSB     = 4;
   localparam int          CTRL_PAT_W       = 4;
   localparam int          INT_RD           = 0;
   localparam int          INT_WR           = 1;
   localparam int          ST_RDDONE        = 0;
   localparam int          ST_WRDONE        = 1;
   localparam int          ST_BUSY          = 2;
   localparam int          CURVE_W          = 2;
   // =========================================================
   // Codes and reset values
   localparam logic [31:0] REQ_OFF          = 32'h0000_0000;
   localparam logic [31:0] REQ_ON           = 32'h0000_0001;
   localparam logic [15:0] RESP_OK          = 16'h0000;
   localparam logic [15:0] RESP_BOTH        = 16'hFF21;
   localparam logic [15:0] RESP_COND        = 16'hFF10;
   localparam logic [15:0] RESP_PARAM       = 16'hFF11;
   localparam logic [1:0]  CURVE_LIN        = 2'h0;
   localparam logic [1:0]  CURVE_PARA       = 2'h1;
   localparam logic [1:0]  CURVE_MAX        = 2'h1;
   localparam logic [31:0] CYCLE_RST        = 32'h0000_1000;
   localparam logic [31:0] STROKE_RST       = 32'h0000_1000;
   localparam logic [31:0] ADVSPD_RST       = 32'h0000_0001;
   localparam logic [31:0] PCHG_RST         = 32'h0000_0001;
   localparam int          PT_FRAC          = 15;
   localparam int          PT_W             = 16;
   localparam logic [15:0] PT_FULL          = 16'h8000;
endpackage

// ---- rtl/ecte_point_gen.sv ----
// Cam curve point generator: displacement of one point of a pattern.
`timescale 1ns/1ps
module ecte_point_gen
   import ecte_pkg::*;
#(
   parameter int NPT = 16
) (
   // Curve selection and point index
   input  wire logic [CURVE_W-1:0]         curve,
   input  wire logic [$clog2(NPT)-1:0]     index,
   // Displacement, PT_FULL is 100%
   output      logic [PT_W-1:0]            point
);
   localparam int LG = $clog2(NPT);
   // Parabolic shift needs PT_FRAC + 1 >= 2 * LG.
   localparam int PSH = PT_FRAC + 1 - 2 * LG;

   logic [PT_W-1:0]   rem;
   logic [2*PT_W-1:0] sq;

   always_comb begin
      rem = PT_W'(NPT) - PT_W'(index);
      sq  = '0;
      if (curve == CURVE_PARA) begin
         // Constant acceleration first half, mirrored deceleration after.
         if (2 * int'(index) < NPT) begin
            sq    = (2*PT_W)'(index) * (2*PT_W)'(index);
            point = PT_W'(sq << PSH);
         end else begin
            sq    = (2*PT_W)'(rem) * (2*PT_W)'(rem);
            point = PT_FULL - PT_W'(sq << PSH);
         end
      end else begin
         point = PT_W'(index) << (PT_FRAC - LG);
      end
   end
endmodule

// ---- rtl/ecte_cam.sv ----
// Electronic cam unit: configuration, point tables, table edit handshake.
//
// What this block does
// - Cam disabled means clutch pulses pass straight to the axis output.
// - Patterns are stored as point data generated from curve and resolution.
// - Master cycle value is the pulse count spanning the full pattern phase.
// - Stroke amount in pulses equals 100% pattern displacement.
// - The pattern-number parameter selects which stored pattern drives slaves.
// - Advance correction applied only when its use setting is on.
// - Edits run only with all axes sync-cancelled, idle, params valid.
// - Read plus rewrite together: read runs, rewrite ends with FF21.
// - Response code is written before the completion flag rises.
// - Completion flag clears once the host drops the request.
// - Request word is 0 for off, 1 for on, reset to off.
// - Normal end reports code 0000, abnormal ends a nonzero code.
`timescale 1ns/1ps
module ecte_cam
   import ecte_pkg::*;
#(
   parameter int NPAT = 4,
   parameter int NPT  = 16,
   parameter int NAX  = 8
) (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   // Register port
   input  wire logic [ECTE_AW-1:0]   regAddr,
   input  wire logic [ECTE_DW-1:0]   regWrData,
   input  wire logic                 regWr,
   input  wire logic                 regRd,
   output      logic [ECTE_DW-1:0]   regRdData,
   // Motion inputs
   input  wire logic signed [31:0]   clutchPulse,
   input  wire logic [15:0]          masterDelta,
   input  wire logic [NAX-1:0]       axisSyncCancelled,
   input  wire logic [NAX-1:0]       axisBusy,
   // Outputs
   output      logic signed [31:0]   axisPulse,
   output      logic                 camActive,
   output      logic                 readDone,
   output      logic                 rewriteDone,
   output      logic                 camIrq
);
   localparam int LG = $clog2(NPT);
   localparam int PW = $clog2(NPAT);
   localparam int SW = $clog2(NPAT * NPT);

   typedef enum logic [1:0] {IDLE, GEN, FIN} ecte_state_type;

   // =========================================================
   // Registers
   logic [7:0]         ctrl_reg;
   logic [31:0]        cycle_reg, stroke_reg, advSpd_reg, pchg_reg;
   logic signed [31:0] advAmt_reg;
   logic [CTRL_PAT_W-1:0] editPat_reg;
   logic [CURVE_W-1:0] editCurve_reg;
   logic               rdReq_reg, wrReq_reg;
   logic [15:0]        rdRes_reg, wrRes_reg;
   logic [1:0]         intStat_reg, intMask_reg;
   ecte_state_type     state_reg;
   logic [LG-1:0]      genIdx_reg;
   logic               finRd_reg, finWr_reg;
   logic [PT_W-1:0]    camPts_reg [NPAT*NPT];
   logic [CURVE_W-1:0] patCurve_reg [NPAT];
   logic [31:0]        phase_reg;
   logic [31:0]        camPos_reg;
   logic [LG-1:0]      idxPrev_reg;

   logic               camEn, advEn, editOk, rdGo, wrGo, rdOk, wrOk;
   logic [PW-1:0]      activePat;
   logic [PT_W-1:0]    genPoint, pointNow;
   logic [LG-1:0]      idxNow;
   logic [SW-1:0]      genAddr;
   logic [31:0]        effPhase, posNow, phaseSum;
   logic signed [33:0] advSum;
   logic [47:0]        prod;
   logic [ECTE_DW-1:0] rdMux;

   function automatic logic [LG-1:0] phaseIndex(input logic [31:0] p,
                                                input logic [31:0] c);
      logic [LG-1:0] idx;
      logic [LG-1:0] trial;
      idx = '0;
      // Successive approximation of floor(p * NPT / c).
      for (int b = LG - 1; b >= 0; b--) begin
         trial = idx | LG'(1 << b);
         if ((64'(p) << LG) >= 64'(trial) * 64'(c)) begin
            idx = trial;
         end
      end
      return idx;
   endfunction

   assign camEn     = ctrl_reg[CTRL_CAMEN];
   assign advEn     = ctrl_reg[CTRL_ADVEN];
   assign activePat = ctrl_reg[CTRL_PAT_LSB +: PW];
   assign editOk    = (&axisSyncCancelled) && !(|axisBusy);
   assign rdOk      = editOk && (int'(editPat_reg) < NPAT);
   assign wrOk      = rdOk && (editCurve_reg <= CURVE_MAX)
                      && (cycle_reg != '0);
   // Requests wait out a bus write cycle, so request words written back to
   // back count as raised together and the read wins over the rewrite.
   assign rdGo      = state_reg == IDLE && rdReq_reg && !readDone && !regWr;
   assign wrGo      = state_reg == IDLE && wrReq_reg && !rewriteDone
                      && !regWr;
   assign genAddr   = SW'(editPat_reg[PW-1:0]) * SW'(NPT) + SW'(genIdx_reg);

   ecte_point_gen #(
      .NPT   (NPT)
   ) u_gen (
      .curve (editCurve_reg),
      .index (genIdx_reg),
      .point (genPoint)
   );

   // =========================================================
   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_reg   <= '0;
         cycle_reg  <= CYCLE_RST;
         stroke_reg <= STROKE_RST;
         advAmt_reg <= '0;
         advSpd_reg <= ADVSPD_RST;
         pchg_reg   <= PCHG_RST;
      end else if (regWr) begin
         if (regAddr == ADDR_CTRL)   ctrl_reg   <= regWrData[7:0];
         if (regAddr == ADDR_CYCLE)  cycle_reg  <= regWrData;
         if (regAddr == ADDR_STROKE) stroke_reg <= regWrData;
         if (regAddr == ADDR_ADVAMT) advAmt_reg <= regWrData;
         if (regAddr == ADDR_ADVSPD) advSpd_reg <= regWrData;
         if (regAddr == ADDR_PCHG)   pchg_reg   <= regWrData;
      end
   end

   // =========================================================
   // Editing area and request words
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         editPat_reg   <= '0;
         editCurve_reg <= CURVE_LIN;
         rdReq_reg     <= 1'b0;
         wrReq_reg     <= 1'b0;
      end else begin
         if (regWr && regAddr == ADDR_EDITPAT)
            editPat_reg <= regWrData[CTRL_PAT_W-1:0];
         // A successful read overrides a same-cycle software write.
         if (rdGo && rdOk)
            editCurve_reg <= patCurve_reg[editPat_reg[PW-1:0]];
         else if (regWr && regAddr == ADDR_EDITCURVE)
            editCurve_reg <= regWrData[CURVE_W-1:0];
         if (regWr && regAddr == ADDR_RDREQ)
            rdReq_reg <= regWrData == REQ_ON;
         if (regWr && regAddr == ADDR_WRREQ)
            wrReq_reg <= regWrData == REQ_ON;
      end
   end

   // =========================================================
   // Edit sequencer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg  <= IDLE;
         genIdx_reg <= '0;
         finRd_reg  <= 1'b0;
         finWr_reg  <= 1'b0;
         rdRes_reg  <= RESP_OK;
         wrRes_reg  <= RESP_OK;
      end else begin
         unique case (state_reg)
            IDLE: begin
               finRd_reg <= 1'b0;
               finWr_reg <= 1'b0;
               if (rdGo) begin
                  rdRes_reg <= rdOk ? RESP_OK : RESP_COND;
                  finRd_reg <= 1'b1;
                  state_reg <= FIN;
                  if (wrGo) begin
                     wrRes_reg <= RESP_BOTH;
                     finWr_reg <= 1'b1;
                  end
               end else if (wrGo) begin
                  if (wrOk) begin
                     genIdx_reg <= '0;
                     state_reg  <= GEN;
                  end else begin
                     wrRes_reg <= editOk ? RESP_PARAM : RESP_COND;
                     finWr_reg <= 1'b1;
                     state_reg <= FIN;
                  end
               end
            end
            GEN: begin
               genIdx_reg <= genIdx_reg + 1'b1;
               if (genIdx_reg == LG'(NPT - 1)) begin
                  wrRes_reg <= RESP_OK;
                  finWr_reg <= 1'b1;
                  state_reg <= FIN;
               end
            end
            FIN: begin
               state_reg <= IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // Completion flags: raised one cycle after the result code lands.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         readDone    <= 1'b0;
         rewriteDone <= 1'b0;
      end else begin
         if (state_reg == FIN && finRd_reg)
            readDone <= 1'b1;
         else if (!rdReq_reg)
            readDone <= 1'b0;
         if (state_reg == FIN && finWr_reg)
            rewriteDone <= 1'b1;
         else if (!wrReq_reg)
            rewriteDone <= 1'b0;
      end
   end

   // =========================================================
   // Point tables, written only by a successful rewrite.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int p = 0; p < NPAT; p++) patCurve_reg[p] <= CURVE_LIN;
      end else if (state_reg == GEN) begin
         camPts_reg[genAddr] <= genPoint;
         if (genIdx_reg == LG'(NPT - 1))
            patCurve_reg[editPat_reg[PW-1:0]] <= editCurve_reg;
      end
   end

   // =========================================================
   // Cam datapath. The advance amount is taken as a fixed phase
   // offset and must stay within one master cycle.
   always_comb begin
      phaseSum = phase_reg + 32'(masterDelta);
      if (phaseSum >= cycle_reg) phaseSum = phaseSum - cycle_reg;
      advSum = 34'(signed'({1'b0, phase_reg})) + 34'(advAmt_reg);
      if (advSum < 0)
         advSum = advSum + 34'(signed'({1'b0, cycle_reg}));
      else if (advSum >= 34'(signed'({1'b0, cycle_reg})))
         advSum = advSum - 34'(signed'({1'b0, cycle_reg}));
      effPhase = advEn ? advSum[31:0] : phase_reg;
      idxNow   = phaseIndex(effPhase, cycle_reg);
      pointNow = camPts_reg[SW'(activePat) * SW'(NPT) + SW'(idxNow)];
      prod     = 48'(stroke_reg) * 48'(pointNow);
      posNow   = prod[PT_FRAC +: 32];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !camEn)
         phase_reg <= '0;
      else
         phase_reg <= phaseSum;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         camPos_reg  <= '0;
         idxPrev_reg <= '0;
         axisPulse   <= '0;
         camActive   <= 1'b0;
      end else begin
         camPos_reg  <= posNow;
         idxPrev_reg <= idxNow;
         camActive   <= camEn;
         if (!camEn)
            axisPulse <= clutchPulse;
         else if (idxNow < idxPrev_reg)
            // A cycle wrap carries the full stroke forward.
            axisPulse <= signed'(posNow - camPos_reg + stroke_reg);
         else
            axisPulse <= signed'(posNow - camPos_reg);
      end
   end

   // =========================================================
   // Interrupts: set wins over a same-cycle write-one clear.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         intStat_reg <= '0;
         intMask_reg <= '0;
         camIrq      <= 1'b0;
      end else begin
         intStat_reg <= (intStat_reg & ~((regWr && regAddr == ADDR_INTSTAT)
                        ? regWrData[1:0] : 2'h0))
                        | {state_reg == FIN && finWr_reg,
                           state_reg == FIN && finRd_reg};
         if (regWr && regAddr == ADDR_INTMASK)
            intMask_reg <= regWrData[1:0];
         camIrq <= |(intStat_reg & intMask_reg);
      end
   end

   // =========================================================
   // Read port
   always_comb begin
      unique case (regAddr)
         ADDR_CTRL:      rdMux = 32'(ctrl_reg);
         ADDR_CYCLE:     rdMux = cycle_reg;
         ADDR_STROKE:    rdMux = stroke_reg;
         ADDR_ADVAMT:    rdMux = advAmt_reg;
         ADDR_ADVSPD:    rdMux = advSpd_reg;
         ADDR_PCHG:      rdMux = pchg_reg;
         ADDR_EDITPAT:   rdMux = 32'(editPat_reg);
         ADDR_EDITCURVE: rdMux = 32'(editCurve_reg);
         ADDR_RDREQ:     rdMux = rdReq_reg ? REQ_ON : REQ_OFF;
         ADDR_WRREQ:     rdMux = wrReq_reg ? REQ_ON : REQ_OFF;
         ADDR_RDRES:     rdMux = 32'(rdRes_reg);
         ADDR_WRRES:     rdMux = 32'(wrRes_reg);
         ADDR_INTSTAT:   rdMux = 32'(intStat_reg);
         ADDR_INTMASK:   rdMux = 32'(intMask_reg);
         ADDR_STATUS:    rdMux = 32'({state_reg != IDLE, rewriteDone,
                                      readDone});
         ADDR_PHASE:     rdMux = phase_reg;
         default:        rdMux = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !regRd)
         regRdData <= '0;
      else
         regRdData <= rdMux;
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   bypass_pulse_a: assert property (
      !camEn |=> axisPulse == $past(clutchPulse))
      else $error("clutch pulse not passed through");
   phase_range_a: assert property (
      camEn && $past(camEn) |-> phase_reg < cycle_reg)
      else $error("phase beyond master cycle");
   stroke_scale_a: assert property (
      pointNow == '0 |=> camPos_reg == '0)
      else $error("zero displacement not zero position");
   gen_point_a: assert property (
      state_reg == GEN |=> camPts_reg[$past(genAddr)] == $past(genPoint))
      else $error("generated point not stored");
   adv_skip_a: assert property (
      !advEn |-> effPhase == phase_reg)
      else $error("advance correction applied while off");
   both_req_a: assert property (
      rdGo && wrGo |=> wrRes_reg == RESP_BOTH ##1 readDone && rewriteDone)
      else $error("simultaneous request mishandled");
   result_first_a: assert property (
      $rose(readDone) |-> $past(finRd_reg) && $stable(rdRes_reg))
      else $error("read flag rose before result");
   done_clear_a: assert property (
      readDone && !rdReq_reg && state_reg != FIN |=> !readDone)
      else $error("read completion not cleared");
   req_encode_a: assert property (
      regWr && regAddr == ADDR_RDREQ |=> rdReq_reg == $past(regWrData == REQ_ON))
      else $error("request word encoding wrong");
   resp_ok_a: assert property (
      state_reg == GEN && genIdx_reg == LG'(NPT - 1)
      |=> wrRes_reg == RESP_OK ##1 rewriteDone)
      else $error("normal rewrite code wrong");
   cond_block_a: assert property (
      wrGo && !rdGo && !editOk |=> state_reg == FIN && wrRes_reg != RESP_OK)
      else $error("refused edit reported normal");
endmodule

// ---- test/ecte_host_model.sv ----
// Host program model: drives the register port of the cam editor.
`timescale 1ns/1ps
module ecte_host_model
   import ecte_pkg::*;
(
   // Clock
   input  wire logic               core_clk,
   // Register port
   output      logic [ECTE_AW-1:0] regAddr,
   output      logic [ECTE_DW-1:0] regWrData,
   output      logic               regWr,
   output      logic               regRd
);
   initial begin
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      regWr = 1'b0;
      regRd = 1'b0;
   end

   // =========================================================
   // Bus cycles
   // Released lines show the inverse, so stale values never pass as held.
   task put(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask

   // Two writes on consecutive cycles, strobe held high between them.
   task put_pair(input logic [7:0] a0, input logic [31:0] d0,
                 input logic [7:0] a1, input logic [31:0] d1);
      @(posedge core_clk);
      regAddr <= a0;
      regWrData <= d0;
      regWr <= 1'b1;
      @(posedge core_clk);
      regAddr <= a1;
      regWrData <= d1;
      @(posedge core_clk);
      regWr <= 1'b0;
      regAddr <= ~a1;
      regWrData <= ~d1;
   endtask

   task get(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      regAddr <= ~a;
   endtask
endmodule

// ---- test/tb.sv ----
// Self-checking testbench for the electronic cam unit.
`timescale 1ns/1ps
module tb
   import ecte_pkg::*;
;
   logic               core_clk;
   logic               rst_n;
   logic [7:0]         regAddr;
   logic [31:0]        regWrData;
   logic               regWr;
   logic               regRd;
   logic [31:0]        regRdData;
   logic signed [31:0] clutchPulse;
   logic [15:0]        masterDelta;
   logic [7:0]         axisSyncCancelled;
   logic [7:0]         axisBusy;
   logic signed [31:0] axisPulse;
   logic               camActive;
   logic               readDone;
   logic               rewriteDone;
   logic               camIrq;
   logic               rdSeen;
   logic [31:0]        expQ[$];
   logic signed [31:0] v;
   logic signed [31:0] sum;
   logic [31:0]        stroke;
   int                 nErrors;
   int                 samplesChecked;
   int                 cycles;
   int                 seed;

   ecte_host_model ecte_host_model_i (.core_clk(core_clk), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd));

   ecte_cam #(.NPAT(4), .NPT(16), .NAX(8)) ecte_cam_i (.core_clk(core_clk),
      .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .clutchPulse(clutchPulse),
      .masterDelta(masterDelta), .axisSyncCancelled(axisSyncCancelled),
      .axisBusy(axisBusy), .axisPulse(axisPulse), .camActive(camActive),
      .readDone(readDone), .rewriteDone(rewriteDone), .camIrq(camIrq));

   // =========================================================
   // Checking helpers
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nErrors++;
         $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
      end
   endtask

   task close_out();
      $display("checks %0d, mismatches %0d", samplesChecked, nErrors);
      if (nErrors == 0 && samplesChecked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      ecte_host_model_i.put(a, d);
   endtask

   task rdx(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      ecte_host_model_i.get(a);
   endtask

   // Polls a done flag; the bound covers the longest rewrite.
   task wait_flag(input bit rd, input logic lvl);
      for (int i = 0; i < 40; i++) begin
         @(posedge core_clk);
         #1;
         if ((rd ? readDone : rewriteDone) === lvl) return;
      end
      chk(32'(rd ? readDone : rewriteDone), 32'(lvl));
   endtask

   // =========================================================
   // Clock, read monitor and watchdog
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (rdSeen) chk(regRdData, expQ.pop_front());
      rdSeen <= regRd;
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         nErrors++;
         close_out();
      end
   end

   // =========================================================
   // Main sequence
   logic [7:0]  tAdr[3] = '{ADDR_ADVAMT, ADDR_ADVSPD, ADDR_PCHG};
   logic [31:0] tVal[3] = '{32'h8000_0400, 32'h7FFF_FC00, 32'h0000_2710};
   logic [7:0]  eBusy[4] = '{8'h08, 8'h00, 8'h00, 8'h00};
   logic [7:0]  eCanc[4] = '{8'hFF, 8'hFE, 8'hFF, 8'hFF};
   logic [31:0] ePat[4] = '{32'h1, 32'h1, 32'h5, 32'h1};
   logic [31:0] eRes[4] = '{RESP_COND, RESP_COND, RESP_PARAM, RESP_OK};
   initial begin
      rst_n = 1'b0;
      clutchPulse = 32'sh0;
      masterDelta = 16'h0000;
      axisSyncCancelled = 8'hFF;
      axisBusy = 8'h00;
      rdSeen = 1'b0;
      cycles = 0;
      seed = 26885;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rdx(ADDR_CTRL, 32'h0);
      rdx(ADDR_CYCLE, CYCLE_RST);
      rdx(ADDR_STROKE, STROKE_RST);
      rdx(ADDR_RDREQ, REQ_OFF);
      rdx(ADDR_RDRES, {16'h0, RESP_OK});
      rdx(8'h7F, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(tAdr[i], tVal[i]);
         rdx(tAdr[i], tVal[i]);
      end
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         @(posedge core_clk);
         clutchPulse <= v;
         @(posedge core_clk);
         #1 chk(axisPulse, v);
      end
      $display("test clutch pass-through done");
      wr(ADDR_EDITPAT, 32'h1);
      wr(ADDR_RDREQ, REQ_ON);
      wait_flag(1'b1, 1'b1);
      rdx(ADDR_RDRES, {16'h0, RESP_OK});
      #1 chk(32'(camIrq), 32'h0);
      wr(ADDR_INTMASK, 32'h1);
      repeat (2) @(posedge core_clk);
      #1 chk(32'(camIrq), 32'h1);
      rdx(ADDR_INTSTAT, 32'h1);
      wr(ADDR_INTSTAT, 32'h1);
      repeat (2) @(posedge core_clk);
      #1 chk(32'(camIrq), 32'h0);
      wr(ADDR_RDREQ, REQ_OFF);
      wait_flag(1'b1, 1'b0);
      $display("test read handshake done");
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         axisBusy <= eBusy[i];
         axisSyncCancelled <= eCanc[i];
         wr(ADDR_EDITPAT, ePat[i]);
         wr(ADDR_EDITCURVE, {30'h0, CURVE_PARA});
         wr(ADDR_WRREQ, REQ_ON);
         wait_flag(1'b0, 1'b1);
         rdx(ADDR_WRRES, eRes[i]);
         wr(ADDR_WRREQ, REQ_OFF);
         wait_flag(1'b0, 1'b0);
      end
      wr(ADDR_EDITCURVE, 32'h0);
      wr(ADDR_RDREQ, REQ_ON);
      wait_flag(1'b1, 1'b1);
      rdx(ADDR_EDITCURVE, {30'h0, CURVE_PARA});
      wr(ADDR_RDREQ, REQ_OFF);
      wait_flag(1'b1, 1'b0);
      ecte_host_model_i.put_pair(ADDR_RDREQ, REQ_ON, ADDR_WRREQ, REQ_ON);
      wait_flag(1'b0, 1'b1);
      rdx(ADDR_STATUS, 32'h3);
      rdx(ADDR_WRRES, {16'h0, RESP_BOTH});
      rdx(ADDR_RDRES, {16'h0, RESP_OK});
      ecte_host_model_i.put_pair(ADDR_RDREQ, REQ_OFF, ADDR_WRREQ, REQ_OFF);
      wait_flag(1'b0, 1'b0);
      $display("test rewrite done");
      stroke = ($random(seed) & 32'h0000_0FFF) | 32'h1;
      wr(ADDR_CYCLE, 32'h40);
      wr(ADDR_STROKE, stroke);
      wr(ADDR_CTRL, 32'h11);
      @(posedge core_clk);
      #1 chk(32'(camActive), 32'h1);
      sum = 32'sh0;
      for (int i = 0; i < 24; i++) begin
         @(posedge core_clk);
         masterDelta <= (i < 16) ? 16'h0004 : 16'h0000;
         #1 sum += axisPulse;
      end
      chk(sum, stroke);
      rdx(ADDR_PHASE, 32'h0);
      // Half a cycle of advance lands on the middle of the curve: 50% stroke.
      wr(ADDR_ADVAMT, 32'h20);
      wr(ADDR_CTRL, 32'h13);
      @(posedge core_clk);
      #1 chk(axisPulse, stroke >> 1);
      repeat (2) @(posedge core_clk);
      $display("test cam cycle done");
      close_out();
   end
endmodule
